//--- hdl/fcct_pkg.sv
// package: register map, fields and constants of the capture/compare timer
package fcct_pkg;
   localparam int NUM_CH = 4;
   localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
   localparam logic [7:0] OFS_FORCE = 8'h01;
   localparam logic [7:0] OFS_CNT_HI = 8'h04;
   localparam logic [7:0] OFS_CNT_LO = 8'h05;
   localparam logic [7:0] OFS_SYS_CTL1 = 8'h06;
   localparam logic [7:0] OFS_TOGGLE_OVF = 8'h07;
   localparam logic [7:0] OFS_OUT_ACT1 = 8'h08;
   localparam logic [7:0] OFS_OUT_LEVEL = 8'h09;
   localparam logic [7:0] OFS_PRESCALE = 8'h0d;
   localparam logic [7:0] OFS_EVT_FLAGS = 8'h0e;
   localparam logic [7:0] OFS_CH_BASE = 8'h10;
   localparam logic [7:0] OFS_CH_MASK = 8'hf0;
   localparam int CTL1_RUN_BIT = 7;
   localparam int CTL1_FAST_CLR_BIT = 4;
   localparam logic [7:0] CTL1_WMASK = 8'h90;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam int PRESCALE_W = 7;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fcct_bus_t;
endpackage

//--- hdl/fcct_prescaler.sv
// prescaler: power-of-two tick generator with glitch-free factor changes
`timescale 1ns/1ps
module fcct_prescaler #(
   parameter int STAGES = fcct_pkg::PRESCALE_W
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic [2:0] sel_in,
   output logic tick_out
);
   logic [STAGES-1:0] cnt_r;
   logic [2:0] sel_act_r;
   logic [STAGES-1:0] mask;
   logic all_zero;
   logic tick_nxt;
   // as many low counter bits as the active factor form the period; factor 0 ticks every clock
   assign mask = STAGES'((8'h01 << sel_act_r) - 8'h01);
   assign all_zero = (cnt_r == '0);
   assign tick_nxt = run_in && ((cnt_r & mask) == mask);
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cnt_r <= '0;
         sel_act_r <= fcct_pkg::PRESCALE_RESET;
         tick_out <= 1'b0;
      end else begin
         tick_out <= tick_nxt;
         if (run_in) begin
            cnt_r <= cnt_r + STAGES'(1);
         end
         // new factor only adopted where all stages are zero, so no short tick
         if (all_zero) begin
            sel_act_r <= sel_in;
         end
      end
   end
   a_tick_period: assert property (p_tick_period);
   property p_tick_period;
      @(posedge ref_clk_in) disable iff (rst_in)
         (run_in && sel_act_r == 3'h1 && $stable(sel_act_r) && cnt_r == 7'h01) |=>
            tick_out;
   endproperty
endmodule

//--- hdl/fcct_channel.sv
// one channel: capture latch or compare match on its own pin
`timescale 1ns/1ps
module fcct_channel (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic is_compare_in,
   input wire logic tick_in,
   input wire logic [15:0] count_in,
   input wire logic pin_in,
   input wire logic wr_hi_in,
   input wire logic wr_lo_in,
   input wire logic [7:0] wdata_in,
   output logic [15:0] value_out,
   output logic event_out
);
   logic pin_d_r;
   logic cap_edge;
   logic cmp_hit;
   assign cap_edge = !is_compare_in && pin_in && !pin_d_r;
   assign cmp_hit = is_compare_in && tick_in && (count_in == value_out);
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pin_d_r <= 1'b0;
         value_out <= fcct_pkg::COUNT_RESET;
         event_out <= 1'b0;
      end else begin
         pin_d_r <= pin_in;
         event_out <= cap_edge || cmp_hit;
         if (cap_edge) begin
            value_out <= count_in;
         end else if (wr_hi_in) begin
            value_out[15:8] <= wdata_in;
         end else if (wr_lo_in) begin
            value_out[7:0] <= wdata_in;
         end
      end
   end
   a_capture_latch: assert property (p_capture_latch);
   property p_capture_latch;
      @(posedge ref_clk_in) disable iff (rst_in)
         cap_edge |=> (value_out == $past(count_in)) && event_out;
   endproperty
endmodule

//--- hdl/fcct_timer.sv
// top: four-channel 16-bit capture/compare timer with register port
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module fcct_timer #(
   parameter logic [7:0] BASE_ADDR = 8'h00
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [3:0] pin_in,
   output logic [7:0] rdata_out,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe_out
);
   localparam int N = fcct_pkg::NUM_CH;
   fcct_pkg::fcct_bus_t bus;
   logic [7:0] ofs;
   logic [3:0] func_sel_r;
   logic [3:0] toggle_ovf_r;
   logic [7:0] out_act1_r;
   logic [3:0] out_level_r;
   logic [2:0] prescale_r;
   logic run_r;
   logic fast_clr_r;
   logic [15:0] count_r;
   logic [3:0] flags_r;
   logic [3:0] flags_nxt;
   logic [7:0] rdata_nxt;
   logic [3:0] pin_nxt;
   logic tick;
   logic [15:0] ch_val [N];
   logic [3:0] ch_evt;
   logic [3:0] force_hit;
   logic [3:0] w1c_clear;
   logic [3:0] fast_clear;
   logic [3:0] ch_rd;
   logic [3:0] ch_wr;
   logic [3:0] act_tog;
   logic [3:0] act_clr;
   logic [3:0] act_set;
   logic in_ch_range;
   logic [1:0] ch_idx;
   logic wr_cnt_hi;
   logic wr_cnt_lo;
   logic cnt_wrap;
   assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
   assign ofs = 8'(bus.addr - BASE_ADDR);
   assign in_ch_range = ((ofs & fcct_pkg::OFS_CH_MASK) == fcct_pkg::OFS_CH_BASE);
   assign ch_idx = ofs[2:1];
   // channels 4..7 of the channel range are not built and take no access
   assign wr_cnt_hi = bus.wr && (ofs == fcct_pkg::OFS_CNT_HI);
   assign wr_cnt_lo = bus.wr && (ofs == fcct_pkg::OFS_CNT_LO);
   assign force_hit = (bus.wr && ofs == fcct_pkg::OFS_FORCE) ?
                      (bus.wdata[3:0] & func_sel_r) : 4'h0;
   // clearing by one needs the timer running; zeros never touch a flag
   assign w1c_clear = (bus.wr && ofs == fcct_pkg::OFS_EVT_FLAGS && run_r) ?
                      bus.wdata[3:0] : 4'h0;
   assign cnt_wrap = tick && (count_r == 16'hffff);
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         logic hit_ch;
         assign hit_ch = in_ch_range && !ofs[3] && (ch_idx == 2'(g));
         assign ch_rd[g] = bus.rd && hit_ch;
         assign ch_wr[g] = bus.wr && hit_ch;
         // fast clear follows the channel's role: read for capture, write for compare
         assign fast_clear[g] = fast_clr_r &&
                                (func_sel_r[g] ? ch_wr[g] : ch_rd[g]);
         assign act_tog[g] = out_act1_r[2*g+1 -: 2] == 2'h1;
         assign act_clr[g] = out_act1_r[2*g+1 -: 2] == 2'h2;
         assign act_set[g] = out_act1_r[2*g+1 -: 2] == 2'h3;
         fcct_channel u_ch (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .is_compare_in(func_sel_r[g]),
            .tick_in(tick),
            .count_in(count_r),
            .pin_in(pin_in[g]),
            .wr_hi_in(ch_wr[g] && !ofs[0] && func_sel_r[g]),
            .wr_lo_in(ch_wr[g] && ofs[0] && func_sel_r[g]),
            .wdata_in(bus.wdata),
            .value_out(ch_val[g]),
            .event_out(ch_evt[g])
         );
         // compare pins follow their action; overflow may also toggle them
         always_comb begin
            pin_nxt[g] = out_level_r[g];
            if (ch_evt[g] && func_sel_r[g] || force_hit[g]) begin
               if (act_tog[g]) begin
                  pin_nxt[g] = !out_level_r[g];
               end else if (act_clr[g]) begin
                  pin_nxt[g] = 1'b0;
               end else if (act_set[g]) begin
                  pin_nxt[g] = 1'b1;
               end
            end else if (cnt_wrap && toggle_ovf_r[g]) begin
               pin_nxt[g] = !out_level_r[g];
            end
         end
      end
   endgenerate
   // a new event wins over a clear in the same cycle
   assign flags_nxt = (flags_r & ~(w1c_clear | fast_clear)) | ch_evt;
   fcct_prescaler #(
      .STAGES(fcct_pkg::PRESCALE_W)
   ) u_pre (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .run_in(run_r),
      .sel_in(prescale_r),
      .tick_out(tick)
   );
   always_comb begin
      rdata_nxt = fcct_pkg::RESET_BYTE;
      if (in_ch_range && !ofs[3]) begin
         rdata_nxt = ofs[0] ? ch_val[ch_idx][7:0] : ch_val[ch_idx][15:8];
      end else begin
         unique case (ofs)
            fcct_pkg::OFS_FUNC_SEL: rdata_nxt = {4'h0, func_sel_r};
            fcct_pkg::OFS_CNT_HI: rdata_nxt = count_r[15:8];
            fcct_pkg::OFS_CNT_LO: rdata_nxt = count_r[7:0];
            fcct_pkg::OFS_SYS_CTL1: rdata_nxt = {run_r, 2'h0, fast_clr_r, 4'h0};
            fcct_pkg::OFS_TOGGLE_OVF: rdata_nxt = {4'h0, toggle_ovf_r};
            fcct_pkg::OFS_OUT_ACT1: rdata_nxt = out_act1_r;
            fcct_pkg::OFS_OUT_LEVEL: rdata_nxt = {4'h0, out_level_r};
            fcct_pkg::OFS_PRESCALE: rdata_nxt = {5'h00, prescale_r};
            fcct_pkg::OFS_EVT_FLAGS: rdata_nxt = {4'h0, flags_r};
            default: rdata_nxt = fcct_pkg::RESET_BYTE;
         endcase
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         func_sel_r <= 4'h0;
         toggle_ovf_r <= 4'h0;
         out_act1_r <= fcct_pkg::RESET_BYTE;
         out_level_r <= 4'h0;
         prescale_r <= fcct_pkg::PRESCALE_RESET;
         run_r <= 1'b0;
         fast_clr_r <= 1'b0;
         flags_r <= 4'h0;
         rdata_out <= fcct_pkg::RESET_BYTE;
         pin_out <= 4'h0;
         pin_oe_out <= 4'h0;
      end else begin
         flags_r <= flags_nxt;
         out_level_r <= pin_nxt;
         pin_out <= pin_nxt;
         pin_oe_out <= func_sel_r;
         rdata_out <= bus.rd ? rdata_nxt : fcct_pkg::RESET_BYTE;
         if (bus.wr) begin
            unique case (ofs)
               fcct_pkg::OFS_FUNC_SEL: func_sel_r <= bus.wdata[3:0];
               fcct_pkg::OFS_TOGGLE_OVF: toggle_ovf_r <= bus.wdata[3:0];
               fcct_pkg::OFS_OUT_ACT1: out_act1_r <= bus.wdata;
               fcct_pkg::OFS_PRESCALE: prescale_r <= bus.wdata[2:0];
               fcct_pkg::OFS_SYS_CTL1: begin
                  run_r <= bus.wdata[fcct_pkg::CTL1_RUN_BIT];
                  fast_clr_r <= bus.wdata[fcct_pkg::CTL1_FAST_CLR_BIT];
               end
               default: begin
               end
            endcase
         end
      end
   end
   // counter: bus writes take priority over a tick in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         count_r <= fcct_pkg::COUNT_RESET;
      end else if (wr_cnt_hi) begin
         count_r[15:8] <= bus.wdata;
      end else if (wr_cnt_lo) begin
         count_r[7:0] <= bus.wdata;
      end else if (tick && run_r) begin
         count_r <= count_r + 16'h0001;
      end
   end
   a_count_step: assert property (p_count_step);
   property p_count_step;
      @(posedge ref_clk_in) disable iff (rst_in)
         (tick && run_r && !wr_cnt_hi && !wr_cnt_lo) |=>
            count_r == 16'($past(count_r) + 16'h0001);
   endproperty
   a_count_hold: assert property (p_count_hold);
   property p_count_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
         (!run_r && !wr_cnt_hi && !wr_cnt_lo) |=> $stable(count_r);
   endproperty
   a_flag_set: assert property (p_flag_set);
   property p_flag_set;
      @(posedge ref_clk_in) disable iff (rst_in)
         ch_evt[0] |=> flags_r[0];
   endproperty
   a_w1c_stopped: assert property (p_w1c_stopped);
   property p_w1c_stopped;
      @(posedge ref_clk_in) disable iff (rst_in)
         (bus.wr && ofs == fcct_pkg::OFS_EVT_FLAGS && !run_r && !fast_clr_r) |=>
            flags_r == ($past(flags_r) | $past(ch_evt));
   endproperty
   a_w1c_clear: assert property (p_w1c_clear);
   property p_w1c_clear;
      @(posedge ref_clk_in) disable iff (rst_in)
         (bus.wr && ofs == fcct_pkg::OFS_EVT_FLAGS && run_r && bus.wdata[1] &&
          !ch_evt[1]) |=> !flags_r[1];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps);
   property p_zero_keeps;
      @(posedge ref_clk_in) disable iff (rst_in)
         (flags_r[2] && !fast_clear[2] && !(bus.wr && ofs == fcct_pkg::OFS_EVT_FLAGS &&
          bus.wdata[2])) |=> flags_r[2];
   endproperty
   a_fast_clr: assert property (p_fast_clr);
   property p_fast_clr;
      @(posedge ref_clk_in) disable iff (rst_in)
         (fast_clr_r && !func_sel_r[3] && ch_rd[3] && !ch_evt[3]) |=> !flags_r[3];
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero);
   property p_unimpl_zero;
      @(posedge ref_clk_in) disable iff (rst_in)
         (bus.rd && ofs == fcct_pkg::OFS_EVT_FLAGS) |=> rdata_out[7:4] == 4'h0;
   endproperty
   a_read_one: assert property (p_read_one);
   property p_read_one;
      @(posedge ref_clk_in) disable iff (rst_in)
         !bus.rd |=> rdata_out == 8'h00;
   endproperty
endmodule

//--- bench/fcct_pin_model.sv
// far-side pin model: drives capture inputs, reads back driven compare pins
`timescale 1ns/1ps
module fcct_pin_model (
   input wire logic ref_clk_in,
   input wire logic [3:0] pulse_in,
   input wire logic [3:0] level_in,
   input wire logic [3:0] drive_in,
   output logic [3:0] pin_out
);
   logic [3:0] held_r = 4'h0;
   logic [1:0] age_r = 2'h0;
   // a capture pulse is held a few cycles so a slow edge detector cannot miss it
   always @(posedge ref_clk_in) begin
      if (pulse_in != 4'h0) begin
         held_r <= pulse_in;
         age_r <= 2'h3;
      end else if (age_r != 2'h0) begin
         age_r <= age_r - 2'h1;
      end else begin
         held_r <= 4'h0;
      end
   end
   // compare pins carry the device level, capture pins the model's own drive
   assign pin_out = (drive_in & level_in) | (~drive_in & held_r);
endmodule

//--- bench/fcct_timer_tb.sv
// self-checking bench of the capture/compare timer
`timescale 1ns/1ps
module fcct_timer_tb;
   localparam logic [7:0] B = 8'h40;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   fcct_pkg::fcct_bus_t bus = '0;
   logic [3:0] pulse = 4'h0;
   logic [3:0] pins;
   logic [7:0] rdata;
   logic [3:0] pout;
   logic [3:0] poe;
   logic pend = 1'b0;
   logic [15:0] expq[$];
   logic [15:0] e;
   logic [15:0] cnt;
   logic [3:0] w;
   int num_errors = 0;
   int n_tests = 0;
   int seed = 32'ha217;
   int cyc = 0;
   int t1;
   int k;

   fcct_timer #(.BASE_ADDR(B)) fcct_timer_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .addr_in(bus.addr), .wdata_in(bus.wdata), .wr_in(bus.wr), .rd_in(bus.rd),
      .pin_in(pins), .rdata_out(rdata), .pin_out(pout), .pin_oe_out(poe));
   fcct_pin_model fcct_pin_model_i (.ref_clk_in(ref_clk_in), .pulse_in(pulse),
      .level_in(pout), .drive_in(poe), .pin_out(pins));

   initial begin
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) cyc <= cyc + 1;

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (num_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // strobes stand one cycle, then the bus idles so no access is repeated
   task automatic put(input logic [7:0] ofs, input logic [7:0] d);
      @(posedge ref_clk_in);
      bus <= '{addr: 8'(B + ofs), wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_in);
      bus <= '0;
   endtask

   // read data is checked by the monitor one cycle later; tol allows a count step
   task automatic get(input logic [7:0] ofs, input logic [7:0] x, input logic [7:0] tol = 0);
      @(posedge ref_clk_in);
      expq.push_back({x, tol});
      bus <= '{addr: 8'(B + ofs), wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_in);
      bus <= '0;
   endtask

   task automatic wait_pin(input logic [3:0] want);
      int c;
      c = 0;
      while (pout !== want) begin
         @(posedge ref_clk_in);
         bus <= '0;
         c++;
         if (c > 2000) begin
            num_errors++;
            tally_and_finish();
         end
      end
   endtask

   always @(posedge ref_clk_in) begin
      if (pend) begin
         e = expq.pop_front();
         chk("rdata", {8'h00, rdata},
            {8'h00, ((rdata - e[15:8]) <= e[7:0]) ? rdata : e[15:8]});
      end
      pend <= bus.rd;
   end

   initial begin
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      get(fcct_pkg::OFS_EVT_FLAGS, 8'h00);
      put(fcct_pkg::OFS_FUNC_SEL, 8'hff);
      put(fcct_pkg::OFS_SYS_CTL1, 8'hff);
      put(fcct_pkg::OFS_TOGGLE_OVF, 8'hf3);
      get(fcct_pkg::OFS_FUNC_SEL, 8'h0f);
      get(fcct_pkg::OFS_SYS_CTL1, 8'h90);
      get(fcct_pkg::OFS_TOGGLE_OVF, 8'h03);
      get(fcct_pkg::OFS_FORCE, 8'h00);
      get(8'h18, 8'h00);
      get(8'h02, 8'h00);
      get(8'hc0, 8'h00);
      put(fcct_pkg::OFS_TOGGLE_OVF, 8'h00);
      put(fcct_pkg::OFS_FUNC_SEL, 8'h01);
      // channels 3..1 matched at count zero while all were compare
      put(fcct_pkg::OFS_EVT_FLAGS, 8'h0e);
      put(fcct_pkg::OFS_OUT_ACT1, 8'h01);
      put(fcct_pkg::OFS_CH_BASE, 8'h00);
      // a warm-up run lets the new factor be adopted before the interval is timed
      for (k = 0; k < 8; k++) begin
         put(fcct_pkg::OFS_PRESCALE, 8'(k));
         put(fcct_pkg::OFS_SYS_CTL1, 8'h80);
         repeat (130) @(posedge ref_clk_in);
         put(fcct_pkg::OFS_SYS_CTL1, 8'h00);
         put(fcct_pkg::OFS_CNT_HI, 8'h00);
         put(fcct_pkg::OFS_CNT_LO, 8'h00);
         put(fcct_pkg::OFS_CH_BASE + 8'h01, 8'h03);
         put(fcct_pkg::OFS_PRESCALE, 8'(k));
         put(fcct_pkg::OFS_SYS_CTL1, 8'h80);
         w = pout ^ 4'h1;
         wait_pin(w);
         t1 = cyc;
         put(fcct_pkg::OFS_CH_BASE + 8'h01, 8'h08);
         wait_pin(w ^ 4'h1);
         chk("interval", 16'(cyc - t1), 16'(5 << k));
      end
      put(fcct_pkg::OFS_SYS_CTL1, 8'h00);
      get(fcct_pkg::OFS_EVT_FLAGS, 8'h01);
      put(fcct_pkg::OFS_EVT_FLAGS, 8'h0f);
      get(fcct_pkg::OFS_EVT_FLAGS, 8'h01);
      put(fcct_pkg::OFS_SYS_CTL1, 8'h80);
      put(fcct_pkg::OFS_EVT_FLAGS, 8'h00);
      get(fcct_pkg::OFS_EVT_FLAGS, 8'h01);
      put(fcct_pkg::OFS_EVT_FLAGS, 8'h0f);
      get(fcct_pkg::OFS_EVT_FLAGS, 8'h00);
      put(fcct_pkg::OFS_SYS_CTL1, 8'h00);
      // low byte kept below 0x80 so a single tick never carries into the high byte
      cnt = (16'($random(seed)) & 16'hff7f) | 16'h0100;
      put(fcct_pkg::OFS_CNT_HI, cnt[15:8]);
      put(fcct_pkg::OFS_CNT_LO, cnt[7:0]);
      get(fcct_pkg::OFS_CNT_HI, cnt[15:8]);
      get(fcct_pkg::OFS_CNT_LO, cnt[7:0]);
      put(fcct_pkg::OFS_SYS_CTL1, 8'h90);
      pulse <= 4'h2;
      put(fcct_pkg::OFS_CH_BASE, cnt[15:8]);
      pulse <= 4'h0;
      put(fcct_pkg::OFS_CH_BASE + 8'h01, cnt[7:0] + 8'h02);
      wait_pin(pout ^ 4'h1);
      get(fcct_pkg::OFS_EVT_FLAGS, 8'h03);
      get(fcct_pkg::OFS_CH_BASE + 8'h02, cnt[15:8]);
      get(fcct_pkg::OFS_CH_BASE + 8'h03, cnt[7:0], 8'h01);
      put(fcct_pkg::OFS_CH_BASE, cnt[15:8]);
      get(fcct_pkg::OFS_EVT_FLAGS, 8'h00);
      put(fcct_pkg::OFS_EVT_FLAGS, 8'h00);
      repeat (3) @(posedge ref_clk_in);
      chk("queue", 16'(expq.size()), 16'h0000);
      tally_and_finish();
   end
endmodule
